// file: pmuc_pkg.sv
// Shared constants and state encodings of the power control block and its serial link
//
// Summary of operation
// - One enable pin per regulator group
// - Far end drives enable pins high or low
// - Reset output low on power-good fault
// - Reset output held low for 260ms
// - Device is serial target only, never clocks
// - Target address 1011011, bit eight is read
// - Serial clock never above 400kHz
// - Writes carry register address then one byte
// - Reads return one register per transaction
// - Master opens each transaction with START
// - Eight-bit units, MSB first, rising edge
// - Receiver acknowledges each unit up to the data byte; host never acknowledges read data
// - Over 160C all regulators switch off
// - Re-enable blocked until 20C cooler
// - Buck outputs soft-start over 400us
// - Buck high side may stay on continuously
// - Buck switching runs from 2MHz timebase
// - Disabled LDO with bleed bit discharges
// - Software enable bit acts on edges
// - Output-good status reads 0 when low
package pmuc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RST_TIMEOUT_MS = 260;
  localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFT_START_US = 400;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BUCK_HZ = 2_000_000;
  localparam int unsigned BUCK_DIV = CLK_HZ / BUCK_HZ;
  localparam int unsigned BUCK_ON_PH = 3;
  localparam int unsigned SS_ON_PH = 1;
  localparam int unsigned SCL_MAX_HZ = 400_000;
  localparam int unsigned SCL_QTR_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  // ---------------------------------------------------------------
  // Serial target address and register map
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h5B;
  localparam logic [7:0] REG_ON = 8'h00;
  localparam logic [7:0] REG_OPT = 8'h01;
  localparam logic [7:0] REG_GOOD = 8'h02;
  localparam logic [7:0] REG_STAT = 8'h03;
  localparam int unsigned OPT_BLEED_LSB = 0;
  localparam int unsigned OPT_FULL_LSB = 4;
  localparam logic [6:0] ON_RST = 7'h00;
  localparam logic [6:0] OPT_RST = 7'h00;
  // ---------------------------------------------------------------
  // Byte kinds and state machines
  // ---------------------------------------------------------------
  localparam logic [1:0] K_ADDR = 2'h0;
  localparam logic [1:0] K_REG = 2'h1;
  localparam logic [1:0] K_DATA = 2'h2;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_RX = 5'h02, S_ACK = 5'h04, S_TX = 5'h08, S_MACK = 5'h10
  } pmuc_slv_state_type;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_START = 4'h2, H_BIT = 4'h4, H_STOP = 4'h8
  } pmuc_host_state_type;
endpackage : pmuc_pkg

// file: pmuc_link_if.sv
// Two-wire link and enable pins between the system host and the power device
`timescale 1ns/1ns
`default_nettype none
interface pmuc_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  logic enable_pin_reg1;
  logic enable_pin_reg2;
  logic enable_pin_reg3;
  logic enable_pin_reg4_reg5;
  logic enable_pin_reg6;
  logic enable_pin_reg7;
  // Open-drain wires with pull-up: low while any driver pulls low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);
  modport dev (input scl, sda, enable_pin_reg1, enable_pin_reg2, enable_pin_reg3,
    enable_pin_reg4_reg5, enable_pin_reg6, enable_pin_reg7, output sda_d_o, sda_d_oe);
  modport host (input sda, output scl_o, scl_oe, sda_h_o, sda_h_oe, enable_pin_reg1,
    enable_pin_reg2, enable_pin_reg3, enable_pin_reg4_reg5, enable_pin_reg6,
    enable_pin_reg7);
endinterface : pmuc_link_if
`default_nettype wire

// file: pmuc_sync.sv
// Two-stage synchroniser for levels entering the clock domain
`timescale 1ns/1ns
`default_nettype none
module pmuc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : pmuc_sync
`default_nettype wire

// file: pmuc_dev.sv
// Power device control: enables, thermal shutdown, reset timer, buck control, serial target
`timescale 1ns/1ns
`default_nettype none
module pmuc_dev #(
  parameter int unsigned RST_TIMEOUT_CYC = pmuc_pkg::RST_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial link and enable pins
  pmuc_link_if.dev LINK,
  // Analog monitors
  input wire logic TEMP_HOT,
  input wire logic TEMP_COOL,
  input wire logic [6:0] POWER_GOOD,
  input wire logic [2:0] DUTY_MAX,
  // Regulator controls
  output logic [6:0] REG_ACTIVE,
  output logic [2:0] HIGH_SIDE_ON,
  output logic [2:0] SOFT_START,
  output logic [3:0] OUTPUT_BLEED_ENABLE,
  // Open-drain system reset
  output logic SYSTEM_RESET_OUT_N_O,
  output logic SYSTEM_RESET_OUT_N_OE
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pmuc_pkg::pmuc_slv_state_type st;
    logic [3:0] cnt;
    logic [1:0] kind;
    logic rw;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic sda_oe;
    logic scl_p;
    logic sda_p;
    logic [6:0] on;
    logic [6:0] sw;
    logic [6:0] opt;
    logic tsd;
    logic [6:0] active;
    logic [2:0][11:0] ss;
    logic [2:0] ss_on;
    logic [2:0] ph;
    logic [2:0] hs;
    logic [3:0] bleed;
    logic [21:0] rcnt;
    logic rst_oe;
  } pmuc_dev_state_type;

  localparam pmuc_dev_state_type DEV_RST = '{
    st: pmuc_pkg::S_IDLE, on: pmuc_pkg::ON_RST, opt: pmuc_pkg::OPT_RST,
    scl_p: 1'b1, sda_p: 1'b1, rst_oe: 1'b1, default: '0};

  pmuc_dev_state_type q;
  pmuc_dev_state_type d;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [19:0] raw;
  logic [19:0] syn;
  logic scl_s;
  logic sda_s;
  logic [5:0] pin_s;
  logic hot_s;
  logic cool_s;
  logic [6:0] good_s;
  logic [2:0] dmax_s;

  assign raw = {LINK.scl, LINK.sda, LINK.enable_pin_reg7, LINK.enable_pin_reg6,
    LINK.enable_pin_reg4_reg5, LINK.enable_pin_reg3, LINK.enable_pin_reg2,
    LINK.enable_pin_reg1, TEMP_HOT, TEMP_COOL, POWER_GOOD, DUTY_MAX};
  assign {scl_s, sda_s, pin_s, hot_s, cool_s, good_s, dmax_s} = syn;

  // All pins and monitors come from outside this clock domain
  pmuc_sync #(.W(20)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(raw),
    .q(syn)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Shared pin drives regulators four and five together
  function automatic logic [6:0] pin_map(input logic [5:0] p);
    pin_map = {p[5], p[4], p[3], p[3], p[2], p[1], p[0]};
  endfunction : pin_map

  // Read data for the addressed register, unmapped reads give zero
  function automatic logic [7:0] reg_read(input logic [7:0] a, input pmuc_dev_state_type s,
    input logic [6:0] good);
    unique case (a)
      pmuc_pkg::REG_ON: reg_read = {1'b0, s.on};
      pmuc_pkg::REG_OPT: reg_read = {1'b0, s.opt};
      pmuc_pkg::REG_GOOD: reg_read = {1'b0, good};
      pmuc_pkg::REG_STAT: reg_read = {s.tsd, s.active};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Serial target and regulator control share one next-state process
  always_comb begin
    logic scl_r;
    logic scl_f;
    logic start;
    logic stop;
    logic ack;
    logic wr;
    logic trig;
    logic [7:0] rd;
    logic [6:0] rise;
    logic [6:0] fall;
    logic [2:0] full;
    scl_r = scl_s & ~q.scl_p;
    scl_f = ~scl_s & q.scl_p;
    start = scl_s & q.scl_p & q.sda_p & ~sda_s;
    stop = scl_s & q.scl_p & ~q.sda_p & sda_s;
    ack = 1'b0;
    wr = 1'b0;
    trig = 1'b0;
    rd = reg_read(q.ptr, q, good_s);
    rise = 7'h00;
    fall = 7'h00;
    full = 3'h0;
    d = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;

    // Serial target: only ever pulls data low, never the clock
    if (stop) begin
      d.st = pmuc_pkg::S_IDLE;
      d.sda_oe = 1'b0;
    end else if (start) begin
      // A repeated start also lands here and keeps the pointer
      d.st = pmuc_pkg::S_RX;
      d.cnt = 4'h0;
      d.kind = pmuc_pkg::K_ADDR;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        pmuc_pkg::S_IDLE: d.st = pmuc_pkg::S_IDLE;
        pmuc_pkg::S_RX: begin
          if (scl_r) begin
            d.sh = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_f && q.cnt == 4'h8) begin
            unique case (q.kind)
              pmuc_pkg::K_ADDR: begin
                ack = (q.sh[7:1] == pmuc_pkg::TARGET_ADDR);
                d.rw = q.sh[0];
              end
              pmuc_pkg::K_REG: begin
                ack = 1'b1;
                d.ptr = q.sh;
              end
              pmuc_pkg::K_DATA: begin
                ack = 1'b1;
                wr = 1'b1;
              end
              default: ack = 1'b0; // Extra bytes are refused
            endcase
            d.st = ack ? pmuc_pkg::S_ACK : pmuc_pkg::S_IDLE;
            d.sda_oe = ack;
          end
        end
        pmuc_pkg::S_ACK: begin
          if (scl_f) begin
            d.cnt = 4'h0;
            if (q.kind == pmuc_pkg::K_ADDR && q.rw) begin
              d.st = pmuc_pkg::S_TX;
              d.sh = rd;
              d.sda_oe = ~rd[7];
            end else begin
              d.st = pmuc_pkg::S_RX;
              d.sda_oe = 1'b0;
              d.kind = q.kind + 2'h1;
            end
          end
        end
        pmuc_pkg::S_TX: begin
          if (scl_f) begin
            if (q.cnt == 4'h7) begin
              d.st = pmuc_pkg::S_MACK;
              d.sda_oe = 1'b0;
            end else begin
              d.cnt = q.cnt + 4'h1;
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        pmuc_pkg::S_MACK: begin
          // One register per read, whatever the master answers
          if (scl_f) begin
            d.st = pmuc_pkg::S_IDLE;
          end
        end
      endcase
    end

    // Register writes
    if (wr && q.ptr == pmuc_pkg::REG_ON) begin
      d.on = q.sh[6:0];
    end
    if (wr && q.ptr == pmuc_pkg::REG_OPT) begin
      d.opt = q.sh[6:0];
    end

    // Software requests follow edges of the enable bits only
    rise = d.on & ~q.on;
    fall = ~d.on & q.on;
    d.sw = (q.sw | rise) & ~fall;

    // Thermal latch with hysteresis from the two comparators
    if (hot_s) begin
      d.tsd = 1'b1;
    end else if (cool_s) begin
      d.tsd = 1'b0;
    end
    // Shutdown drops software requests so a fresh edge is needed after
    if (d.tsd) begin
      d.sw = 7'h00;
    end
    d.active = d.tsd ? 7'h00 : (pin_map(pin_s) | d.sw);

    // Buck timebase: one phase counter wraps at the switching rate
    d.ph = (q.ph == 3'(pmuc_pkg::BUCK_DIV - 1)) ? 3'h0 : q.ph + 3'h1;
    for (int i = 0; i < 3; i++) begin
      if (d.active[i] && !q.active[i]) begin
        d.ss[i] = 12'(pmuc_pkg::SOFT_START_CYC - 1);
      end else if (!d.active[i]) begin
        d.ss[i] = 12'h000;
      end else if (q.ss[i] != 12'h000) begin
        d.ss[i] = q.ss[i] - 12'h001;
      end
      d.ss_on[i] = d.active[i] && (d.ss[i] != 12'h000);
      // Soft start limits on-time, so the output can only rise slowly
      full[i] = (dmax_s[i] | q.opt[pmuc_pkg::OPT_FULL_LSB + i]) & ~d.ss_on[i];
      d.hs[i] = d.active[i] & (full[i] |
        (d.ph < (d.ss_on[i] ? 3'(pmuc_pkg::SS_ON_PH) : 3'(pmuc_pkg::BUCK_ON_PH))));
    end

    // Discharge paths of disabled LDOs
    d.bleed = ~d.active[6:3] & q.opt[pmuc_pkg::OPT_BLEED_LSB +: 4];

    // Reset output: any active regulator below its good level retriggers
    trig = |(q.active & ~good_s);
    if (trig) begin
      d.rcnt = 22'h000000;
      d.rst_oe = 1'b1;
    end else if (q.rst_oe) begin
      if (q.rcnt == 22'(RST_TIMEOUT_CYC - 1)) begin
        d.rst_oe = 1'b0;
      end else begin
        d.rcnt = q.rcnt + 22'h000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open-drain pins only ever drive low
  assign LINK.sda_d_o = 1'b0;
  assign LINK.sda_d_oe = q.sda_oe;
  assign REG_ACTIVE = q.active;
  assign HIGH_SIDE_ON = q.hs;
  assign SOFT_START = q.ss_on;
  assign OUTPUT_BLEED_ENABLE = q.bleed;
  assign SYSTEM_RESET_OUT_N_O = 1'b0;
  assign SYSTEM_RESET_OUT_N_OE = q.rst_oe;
endmodule : pmuc_dev
`default_nettype wire

// file: pmuc_host.sv
// System host end: drives enable pins and runs single-byte serial transfers
`timescale 1ns/1ns
`default_nettype none
module pmuc_host (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial link and enable pins
  pmuc_link_if.host LINK,
  // Enable requests
  input wire logic [5:0] EN_REQ,
  // Command
  input wire logic CMD_VALID,
  input wire logic CMD_READ,
  input wire logic [7:0] CMD_REG,
  input wire logic [7:0] CMD_DATA,
  output logic CMD_READY,
  // Response
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_NACK
);
  typedef struct packed {
    pmuc_pkg::pmuc_host_state_type st;
    logic [1:0] ph;
    logic [2:0] qdiv;
    logic [1:0] unit;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic [7:0] radr;
    logic [7:0] dat;
    logic [7:0] rx;
    logic scl_oe;
    logic sda_oe;
    logic [5:0] en;
    logic ready;
    logic rv;
    logic nack;
  } pmuc_host_state_type2_type;

  localparam pmuc_host_state_type2_type HOST_RST = '{
    st: pmuc_pkg::H_IDLE, ready: 1'b1, default: '0};

  pmuc_host_state_type2_type q;
  pmuc_host_state_type2_type d;
  logic sda_s;

  // Data line comes back from the far end
  pmuc_sync #(.W(1)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(LINK.sda),
    .q(sda_s)
  );

  // Byte sent in each unit: address, register, address again or data, idle read
  function automatic logic [7:0] unit_byte(input logic [1:0] u, input logic r,
    input logic [7:0] a, input logic [7:0] w);
    unique case (u)
      2'h0: unit_byte = {pmuc_pkg::TARGET_ADDR, 1'b0};
      2'h1: unit_byte = a;
      2'h2: unit_byte = r ? {pmuc_pkg::TARGET_ADDR, 1'b1} : w;
      default: unit_byte = 8'hFF;
    endcase
  endfunction : unit_byte

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic qen;
    logic last;
    qen = (q.qdiv == 3'(pmuc_pkg::SCL_QTR_CYC - 1));
    last = q.rd ? (q.unit == 2'h3) : (q.unit == 2'h2);
    d = q;
    d.rv = 1'b0;
    d.en = EN_REQ;
    d.qdiv = qen ? 3'h0 : q.qdiv + 3'h1;
    if (qen && q.st != pmuc_pkg::H_IDLE) begin
      d.ph = q.ph + 2'h1;
    end
    unique case (q.st)
      pmuc_pkg::H_IDLE: begin
        if (CMD_VALID) begin
          d.st = pmuc_pkg::H_START;
          d.rd = CMD_READ;
          d.radr = CMD_REG;
          d.dat = CMD_DATA;
          d.unit = 2'h0;
          d.ph = 2'h0;
          d.qdiv = 3'h0;
          d.nack = 1'b0;
          d.ready = 1'b0;
        end
      end
      pmuc_pkg::H_START: begin
        // Data falls while the clock is high
        if (qen) begin
          unique case (q.ph)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.st = pmuc_pkg::H_BIT;
              d.bitn = 4'h0;
              d.sh = unit_byte(q.unit, q.rd, q.radr, q.dat);
            end
          endcase
        end
      end
      pmuc_pkg::H_BIT: begin
        if (qen) begin
          unique case (q.ph)
            2'h0: d.sda_oe = (q.bitn < 4'h8) ? ~q.sh[7] : 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitn < 4'h8) begin
                d.rx = {q.rx[6:0], sda_s};
              end else if (sda_s && q.unit != 2'h3) begin
                d.nack = 1'b1;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              if (q.bitn < 4'h8) begin
                d.bitn = q.bitn + 4'h1;
                d.sh = {q.sh[6:0], 1'b1};
              end else if (q.nack || last) begin
                d.st = pmuc_pkg::H_STOP;
              end else if (q.rd && q.unit == 2'h1) begin
                d.unit = 2'h2;
                d.st = pmuc_pkg::H_START;
              end else begin
                d.unit = q.unit + 2'h1;
                d.bitn = 4'h0;
                d.sh = unit_byte(q.unit + 2'h1, q.rd, q.radr, q.dat);
              end
            end
          endcase
        end
      end
      pmuc_pkg::H_STOP: begin
        // Data rises while the clock is high
        if (qen) begin
          unique case (q.ph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: begin
              d.st = pmuc_pkg::H_IDLE;
              d.ready = 1'b1;
              d.rv = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign LINK.scl_o = 1'b0;
  assign LINK.scl_oe = q.scl_oe;
  assign LINK.sda_h_o = 1'b0;
  assign LINK.sda_h_oe = q.sda_oe;
  assign {LINK.enable_pin_reg7, LINK.enable_pin_reg6, LINK.enable_pin_reg4_reg5,
    LINK.enable_pin_reg3, LINK.enable_pin_reg2, LINK.enable_pin_reg1} = q.en;
  assign CMD_READY = q.ready;
  assign RSP_VALID = q.rv;
  assign RSP_DATA = q.rx;
  assign RSP_NACK = q.nack;
endmodule : pmuc_host
`default_nettype wire

// file: pmuc_chk_asserts.sv
// Concurrent checks on the link and the device controls
`timescale 1ns/1ns
`default_nettype none
module pmuc_chk #(
  parameter int unsigned RST_TIMEOUT_CYC = 200
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link
  input wire logic scl,
  input wire logic sda_d_oe,
  input wire logic enable_pin_reg4_reg5,
  // Device
  input wire logic TEMP_HOT,
  input wire logic TEMP_COOL,
  input wire logic [6:0] POWER_GOOD,
  input wire logic [2:0] DUTY_MAX,
  input wire logic [6:0] REG_ACTIVE,
  input wire logic [2:0] HIGH_SIDE_ON,
  input wire logic [2:0] SOFT_START,
  input wire logic [3:0] OUTPUT_BLEED_ENABLE,
  input wire logic SYSTEM_RESET_OUT_N_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ---
  // Helper
  // ---
  // Cycles the reset pin has been pulled low so far
  logic [31:0] low_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      low_q <= 32'h0;
    end else if (SYSTEM_RESET_OUT_N_OE) begin
      low_q <= low_q + 32'h1;
    end else begin
      low_q <= 32'h0;
    end
  end
  // ---
  // Assertions
  // ---
  // Target may only move SDA while SCL is low, so its bits hold through the high phase
  chk_ack_low_phase: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("target SDA moved while SCL high");
  chk_hot_all_off: assert property (TEMP_HOT [*4] |-> REG_ACTIVE == 7'h00)
    else $error("regulator on while hot");
  chk_cool_restore: assert property ((enable_pin_reg4_reg5 && !TEMP_HOT && TEMP_COOL) [*6]
    |-> REG_ACTIVE[4:3] == 2'h3) else $error("shared pin did not enable pair");
  chk_good_trigger: assert property ((|(REG_ACTIVE & ~POWER_GOOD)) [*4]
    |-> SYSTEM_RESET_OUT_N_OE) else $error("reset pin not low on fault");
  chk_rst_timeout: assert property ($fell(SYSTEM_RESET_OUT_N_OE)
    |-> low_q >= RST_TIMEOUT_CYC) else $error("reset pin released early");
  chk_bleed_off: assert property ($stable(REG_ACTIVE) [*2]
    |-> (OUTPUT_BLEED_ENABLE & REG_ACTIVE[6:3]) == 4'h0) else $error("bleed on live LDO");
  chk_full_duty: assert property ((DUTY_MAX[0] && REG_ACTIVE[0] && !SOFT_START[0]) [*6]
    |-> HIGH_SIDE_ON[0]) else $error("full duty not continuous");
  chk_soft_pulse: assert property ((SOFT_START[0] && HIGH_SIDE_ON[0]) ##1 SOFT_START[0]
    |-> !HIGH_SIDE_ON[0]) else $error("soft start pulse too long");
  // Past the end of soft start each switching pulse lasts three of the five timebase cycles;
  // the pulse in the cycle soft start ends may be cut short by the phase counter
  chk_buck_on_time: assert property ($rose(HIGH_SIDE_ON[0]) && !$past(SOFT_START[0])
    && !SOFT_START[0] |=> (HIGH_SIDE_ON[0] || !REG_ACTIVE[0]) [*2])
    else $error("switching pulse too short");
  cov_reset_release: cover property ($fell(SYSTEM_RESET_OUT_N_OE));
  cov_target_drive: cover property ($rose(sda_d_oe));
  cov_hot_off: cover property (TEMP_HOT ##4 REG_ACTIVE == 7'h00);
endmodule : pmuc_chk
`default_nettype wire

// file: pmuc_tb.sv
// Bench: host and device ends facing each other over the link
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int unsigned TO = 200;
  // ---
  // Signals
  // ---
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [5:0] en = 6'h00;
  logic cv = 1'b0;
  logic crd = 1'b0;
  logic [7:0] creg = 8'h00;
  logic [7:0] cdat = 8'h00;
  logic hot = 1'b0;
  logic cool = 1'b1;
  logic [6:0] pg = 7'h7F;
  logic [2:0] duty = 3'h0;
  logic rdy, rv, nack, roe;
  logic [7:0] rd;
  logic [6:0] act;
  logic [2:0] hs, ss;
  logic [3:0] bl;
  logic [8:0] wire_q;
  int n_bits = 9;
  int n_fail = 0;
  int n_tests = 0;
  always #50 CLK = ~CLK;
  // ---
  // Ends under test
  // ---
  pmuc_link_if pmuc_link_if_i ();
  pmuc_host pmuc_host_i (.CLK(CLK), .RST(RST), .LINK(pmuc_link_if_i), .EN_REQ(en),
    .CMD_VALID(cv), .CMD_READ(crd), .CMD_REG(creg), .CMD_DATA(cdat), .CMD_READY(rdy),
    .RSP_VALID(rv), .RSP_DATA(rd), .RSP_NACK(nack));
  pmuc_dev #(.RST_TIMEOUT_CYC(TO)) pmuc_dev_i (.CLK(CLK), .RST(RST), .LINK(pmuc_link_if_i),
    .TEMP_HOT(hot), .TEMP_COOL(cool), .POWER_GOOD(pg), .DUTY_MAX(duty), .REG_ACTIVE(act),
    .HIGH_SIDE_ON(hs), .SOFT_START(ss), .OUTPUT_BLEED_ENABLE(bl),
    .SYSTEM_RESET_OUT_N_O(), .SYSTEM_RESET_OUT_N_OE(roe));
  pmuc_chk #(.RST_TIMEOUT_CYC(TO)) pmuc_chk_i (.CLK(CLK), .RST(RST),
    .scl(pmuc_link_if_i.scl), .sda_d_oe(pmuc_link_if_i.sda_d_oe),
    .enable_pin_reg4_reg5(pmuc_link_if_i.enable_pin_reg4_reg5), .TEMP_HOT(hot),
    .TEMP_COOL(cool), .POWER_GOOD(pg), .DUTY_MAX(duty), .REG_ACTIVE(act),
    .HIGH_SIDE_ON(hs), .SOFT_START(ss), .OUTPUT_BLEED_ENABLE(bl),
    .SYSTEM_RESET_OUT_N_OE(roe));
  // START seen on the wire: restart the unit capture
  always @(negedge pmuc_link_if_i.sda) begin
    if (pmuc_link_if_i.scl === 1'b1) begin
      n_bits = 0;
    end
  end
  // Capture first unit plus its acknowledge on SCL rise
  always @(posedge pmuc_link_if_i.scl) begin
    if (n_bits < 9) begin
      wire_q = {wire_q[7:0], pmuc_link_if_i.sda};
      n_bits++;
    end
  end
  // ---
  // Tasks
  // ---
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One whole transfer, bounded wait for the response pulse
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] w);
    int k;
    k = 0;
    cv = 1'b1;
    crd = r;
    creg = a;
    cdat = w;
    cyc(1);
    cv = 1'b0;
    do begin
      cyc(1);
      k++;
    end while (rv !== 1'b1 && k < 3000);
    chk({7'h00, rv}, 8'h01, "response");
    chk({7'h00, rdy}, 8'h01, "ready");
    chk({7'h00, nack}, 8'h00, "acknowledge");
    chk(wire_q[8:1], {7'h5B, r}, "address unit");
    chk({7'h00, wire_q[0]}, 8'h00, "address ack");
  endtask : xfer
  task automatic hi(output int c);
    c = 0;
    repeat (10) begin
      cyc(1);
      if (hs[0] === 1'b1) c++;
    end
  endtask : hi
  task automatic t_pins;
    logic [6:0] exp [6];
    exp = '{7'h01, 7'h02, 7'h04, 7'h18, 7'h20, 7'h40};
    chk({7'h00, roe}, 8'h01, "reset low");
    cyc(TO + 20);
    chk({7'h00, roe}, 8'h00, "reset released");
    for (int i = 0; i < 6; i++) begin
      en = 6'h01 << i;
      cyc(5);
      chk({1'b0, act}, {1'b0, exp[i]}, "pin");
    end
    en = 6'h00;
    cyc(5);
    chk({1'b0, act}, 8'h00, "pins low");
    $display("test pins done");
  endtask : t_pins
  task automatic t_sw;
    xfer(1'b0, 8'h00, 8'h01);
    cyc(5);
    chk({1'b0, act}, 8'h01, "sw on");
    xfer(1'b1, 8'h00, 8'h00);
    chk(rd, 8'h01, "readback");
    xfer(1'b0, 8'h00, 8'h00);
    cyc(5);
    chk({1'b0, act}, 8'h00, "sw off");
    pg = 7'h55;
    xfer(1'b1, 8'h02, 8'h00);
    chk(rd, 8'h55, "good bits");
    xfer(1'b1, 8'h1F, 8'h00);
    chk(rd, 8'h00, "unmapped");
    pg = 7'h7F;
    $display("test software done");
  endtask : t_sw
  task automatic t_thermal;
    en = 6'h01;
    cyc(5);
    hot = 1'b1;
    cool = 1'b0;
    cyc(6);
    chk({1'b0, act}, 8'h00, "hot off");
    xfer(1'b1, 8'h03, 8'h00);
    chk(rd, 8'h80, "shutdown status");
    hot = 1'b0;
    cyc(6);
    chk({1'b0, act}, 8'h00, "blocked");
    cool = 1'b1;
    cyc(6);
    chk({1'b0, act}, 8'h01, "cooled");
    en = 6'h00;
    $display("test thermal done");
  endtask : t_thermal
  task automatic t_trig;
    pg = 7'h7D;
    en = 6'h02;
    cyc(6);
    chk({7'h00, roe}, 8'h01, "fault");
    cyc(TO);
    pg = 7'h7F;
    cyc(TO - 20);
    chk({7'h00, roe}, 8'h01, "restarted");
    cyc(40);
    chk({7'h00, roe}, 8'h00, "released");
    en = 6'h00;
    $display("test reset pin done");
  endtask : t_trig
  task automatic t_buck;
    int c;
    xfer(1'b0, 8'h01, 8'h01);
    cyc(5);
    chk({4'h0, bl}, 8'h01, "bleed");
    en = 6'h09;
    duty = 3'h1;
    cyc(5);
    chk({4'h0, bl}, 8'h00, "no bleed");
    chk({5'h00, ss}, 8'h01, "soft start");
    hi(c);
    chk(8'(c), 8'h02, "soft pulses");
    cyc(4000);
    chk({5'h00, ss}, 8'h00, "ramp over");
    hi(c);
    chk(8'(c), 8'h0A, "full duty");
    duty = 3'h0;
    cyc(5);
    hi(c);
    chk(8'(c), 8'h06, "timebase");
    en = 6'h00;
    $display("test buck done");
  endtask : t_buck
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    cyc(5);
    RST = 1'b0;
    t_pins();
    t_sw();
    t_thermal();
    t_trig();
    t_buck();
    complete_run();
  end
  // Watchdog well past the expected run length
  initial begin
    #4000000;
    n_fail++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
